// ### testbench/encoder_model.sv
`timescale 1ns/10ps
module encoder_model (
	input  wire logic mclk,
	output logic      phase_a_in,
	output logic      phase_b_in,
	output logic      index_in,
	output logic      home_in,
	output logic      count_gate_in
);
	// ----------------------------------------
	// Encoder state
	// ----------------------------------------
	// Gray order 00,10,11,01 (A,B): one line moves per step
	logic [1:0] pos;
	initial begin
		pos = 2'h0;
		{phase_a_in, phase_b_in, index_in, home_in, count_gate_in} = 5'h00;
	end

	// ----------------------------------------
	// Line movements
	// ----------------------------------------
	// Eight cycles between edges, well over twice the count clock need
	task automatic settle();
		repeat (8) @(posedge mclk);
	endtask

	task automatic drive(input logic [1:0] s);
		@(posedge mclk);
		pos = s;
		phase_a_in <= s[0] ^ s[1];
		phase_b_in <= s[1];
		settle();
	endtask

	task automatic step(input logic up);
		drive(up ? pos + 2'h1 : pos - 2'h1);
	endtask

	// Both lines at once: only when a scenario asks for a bad encoder
	task automatic jump();
		drive(pos + 2'h2);
	endtask

	// Two-cycle spike on A, shorter than the filter window
	task automatic glitch();
		@(posedge mclk);
		phase_a_in <= ~phase_a_in;
		repeat (2) @(posedge mclk);
		phase_a_in <= ~phase_a_in;
		settle();
	endtask

	task automatic pulse(input logic home);
		@(posedge mclk);
		if (home) begin
			home_in <= 1'h1;
		end else begin
			index_in <= 1'h1;
		end
		settle();
		@(posedge mclk);
		home_in <= 1'h0;
		index_in <= 1'h0;
		settle();
	endtask

	task automatic set_gate(input logic v);
		@(posedge mclk);
		count_gate_in <= v;
		settle();
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	import qdec_pkg::*;
	logic        mclk;
	logic        sys_rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        phase_a_in;
	logic        phase_b_in;
	logic        index_in;
	logic        home_in;
	logic        count_gate_in;
	logic        system_idle;
	logic        count_direction;
	logic [31:0] rd;
	logic [3:0]  lanes;
	int          errors;
	int          total_checks;
	int          cyc = 0;

	quadrature_position_decoder i_quadrature_position_decoder (
		.mclk (mclk), .sys_rst (sys_rst), .avs_address (avs_address), .avs_read (avs_read),
		.avs_write (avs_write), .avs_byteenable (avs_byteenable),
		.avs_writedata (avs_writedata), .avs_readdata (avs_readdata),
		.avs_waitrequest (avs_waitrequest), .phase_a_in (phase_a_in),
		.phase_b_in (phase_b_in), .index_in (index_in), .home_in (home_in),
		.count_gate_in (count_gate_in), .system_idle (system_idle),
		.count_direction (count_direction));
	encoder_model i_encoder_model (.mclk (mclk), .phase_a_in (phase_a_in),
		.phase_b_in (phase_b_in), .index_in (index_in), .home_in (home_in),
		.count_gate_in (count_gate_in));

	// ----------------------------------------
	// Clock and bookkeeping
	// ----------------------------------------
	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// Avalon master
	// ----------------------------------------
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= lanes;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		if (avs_waitrequest !== 1'h0) begin
			errors++;
			tally_and_finish();
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	function automatic logic [1:0] match_lv();
		return {phase_b_in, phase_a_in};
	endfunction

	// No capture enables exist here, so modes 2-7 always run with them clear
	task automatic idx_ctl(input logic [2:0] m, input logic hit);
		bus(1'h1, OFS_CONTROL, {16'h0000, 1'h1, 2'h0, m, hit ? match_lv() : ~match_lv(),
			8'h00});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rchk(OFS_CONTROL, 32'h0000_0000);
		chk(32'(count_direction), 32'h0000_0000);
		bus(1'h1, OFS_CONTROL, 32'hFFFF_FFFF);
		rchk(OFS_CONTROL, 32'h0000_BF7F);
		lanes = 4'h1;
		bus(1'h1, OFS_CONTROL, 32'h0000_0000);
		lanes = 4'hF;
		rchk(OFS_CONTROL, 32'h0000_BF00);
		bus(1'h1, OFS_CONTROL, 32'h0000_0000);
		rchk(5'h18, 32'h0000_0000);
	endtask

	task automatic t_quad();
		bus(1'h1, OFS_CONTROL, 32'h0000_8000);
		bus(1'h1, OFS_POSITION, 32'h0000_0000);
		repeat (4) i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0004);
		chk(32'(count_direction), 32'h0000_0001);
		repeat (2) i_encoder_model.step(1'h0);
		rchk(OFS_POSITION, 32'h0000_0002);
		chk(32'(count_direction), 32'h0000_0000);
		i_encoder_model.jump();
		rchk(OFS_POSITION, 32'h0000_0002);
		chk(32'(count_direction), 32'h0000_0000);
		i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0003);
		i_encoder_model.glitch();
		rchk(OFS_POSITION, 32'h0000_0003);
		chk(32'(count_direction), 32'h0000_0001);
		bus(1'h0, OFS_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_003F, {27'h0, 3'h0, phase_b_in, phase_a_in} << 1 | 32'h1);
	endtask

	// Lines are put back while frozen so no stale step shows on re-enable
	task automatic t_enable_idle();
		bus(1'h1, OFS_CONTROL, 32'h0000_0000);
		i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0003);
		i_encoder_model.step(1'h0);
		bus(1'h1, OFS_INIT_VALUE, 32'hA5A5_5A5A);
		rchk(OFS_INIT_VALUE, 32'hA5A5_5A5A);
		bus(1'h1, OFS_CONTROL, 32'h0000_A000);
		system_idle <= 1'h1;
		i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0003);
		i_encoder_model.step(1'h0);
		bus(1'h1, OFS_CONTROL, 32'h0000_8000);
		i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0004);
		system_idle <= 1'h0;
	endtask

	task automatic t_index();
		bus(1'h1, OFS_POSITION, 32'h0000_0055);
		idx_ctl(3'h0, 1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0055);
		idx_ctl(3'h1, 1'h0);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0055);
		idx_ctl(3'h1, 1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0000);
		bus(1'h1, OFS_INIT_VALUE, 32'h1234_5678);
		idx_ctl(3'h2, 1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h1234_5678);
		bus(1'h1, OFS_POSITION, 32'h0000_0055);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0055);
		idx_ctl(3'h3, 1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0055);
		i_encoder_model.pulse(1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h1234_5678);
		bus(1'h1, OFS_POSITION, 32'h0000_0055);
		idx_ctl(3'h4, 1'h1);
		i_encoder_model.pulse(1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0055);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h1234_5678);
	endtask

	task automatic t_bounds();
		bus(1'h1, OFS_GE_COMPARE, 32'h0000_0003);
		bus(1'h1, OFS_LE_COMPARE, 32'h0000_0000);
		bus(1'h1, OFS_POSITION, 32'h0000_0000);
		idx_ctl(3'h5, 1'h1);
		repeat (3) i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0000);
		idx_ctl(3'h6, 1'h1);
		bus(1'h1, OFS_POSITION, 32'h0000_0003);
		i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0000);
		i_encoder_model.step(1'h0);
		rchk(OFS_POSITION, 32'h0000_0003);
		idx_ctl(3'h7, 1'h1);
		i_encoder_model.pulse(1'h0);
		rchk(OFS_POSITION, 32'h0000_0000);
	endtask

	// Prescaler phase is unknown at start, so one tick of slack
	task automatic timer_rate(input logic [15:0] ctl, input int sgn, input logic ix);
		int          div;
		int          c0;
		logic [31:0] p0;
		logic [31:0] d;
		logic [31:0] e;
		div = (ctl[6:4] == 3'h7) ? 256 : (1 << ctl[6:4]);
		bus(1'h1, OFS_CONTROL, {16'h0000, ctl});
		bus(1'h0, OFS_POSITION, 32'h0000_0000);
		p0 = rd;
		c0 = cyc;
		if (ix) begin
			i_encoder_model.pulse(1'h0);
		end else begin
			repeat (4 * div) @(posedge mclk);
		end
		bus(1'h0, OFS_POSITION, 32'h0000_0000);
		d = rd - p0;
		e = 32'(sgn * ((cyc - c0) / div));
		// Unknown read data leaves the slack test unknown, so it still fails
		chk((d - e + 32'h0000_0001 <= 32'h0000_0002) ? e : d, e);
	endtask

	task automatic t_timer();
		for (int c = 0; c < 8; c++) begin
			timer_rate(16'h8003 | (16'(c) << 4), 1, 1'h0);
		end
		timer_rate(16'h800B, -1, 1'h0);
		timer_rate(16'h8403, 1, 1'h1);
		timer_rate(16'h8007, 0, 1'h0);
		i_encoder_model.set_gate(1'h1);
		timer_rate(16'h8007, 1, 1'h0);
		bus(1'h1, OFS_CONTROL, 32'h0000_8001);
		bus(1'h1, OFS_POSITION, 32'h0000_0000);
		repeat (4) i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0001);
		repeat (4) i_encoder_model.step(1'h0);
		rchk(OFS_POSITION, 32'h0000_0000);
		bus(1'h1, OFS_CONTROL, 32'h0000_8002);
		repeat (4) i_encoder_model.step(1'h1);
		rchk(OFS_POSITION, 32'h0000_0001);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'h1;
		avs_address = 5'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0000_0000;
		system_idle = 1'h0;
		lanes = 4'hF;
		errors = 0;
		total_checks = 0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'h0;
		t_regs();
		t_quad();
		t_enable_idle();
		t_index();
		t_bounds();
		t_timer();
		tally_and_finish();
	end
endmodule

// ### verilog/input_noise_filter.sv
`timescale 1ns/10ps
module input_noise_filter
	import qdec_pkg::*;
(
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic raw_in,
	output logic      clean_out
);

	filt_t st;
	filt_t next_st;

	// ----------------------------------------
	// Stability filter
	// ----------------------------------------
	// Glitches shorter than the window never reach the decoder
	always_comb begin
		next_st = st;
		if (raw_in == st.out) begin
			next_st.cnt = 2'h0;
		end else if (st.cnt == FILTER_LAST) begin
			next_st.out = raw_in;
			next_st.cnt = 2'h0;
		end else begin
			next_st.cnt = st.cnt + 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign clean_out = st.out;

endmodule

// ### verilog/phase_step_decoder.sv
`timescale 1ns/10ps
module phase_step_decoder
	import qdec_pkg::*;
(
	input  phase_t prev_phase,
	input  phase_t cur_phase,
	output step_t  step
);

	// ----------------------------------------
	// Transition decode
	// ----------------------------------------
	always_comb begin
		step = '0;
		case ({prev_phase, cur_phase})
			4'hB, 4'h2, 4'hD, 4'h4: step.up = 1'b1;
			4'hE, 4'h8, 4'h7, 4'h1: step.down = 1'b1;
			4'h9, 4'h6, 4'hC, 4'h3: step.bad = 1'b1;
			default: step = '0;
		endcase
	end

endmodule

// ### verilog/qdec_pkg.sv
package qdec_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_CONTROL    = 5'h00;
	localparam logic [4:0] OFS_POSITION   = 5'h04;
	localparam logic [4:0] OFS_INIT_VALUE = 5'h08;
	localparam logic [4:0] OFS_GE_COMPARE = 5'h0C;
	localparam logic [4:0] OFS_LE_COMPARE = 5'h10;
	localparam logic [4:0] OFS_STATUS     = 5'h14;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int BIT_MODULE_ENABLE  = 15;
	localparam int BIT_STOP_IN_IDLE   = 13;
	localparam int POS_INIT_MODE_LSB  = 10;
	localparam int INDEX_MATCH_LSB    = 8;
	localparam int CLOCK_DIVIDER_LSB  = 4;
	localparam int BIT_POLARITY       = 3;
	localparam int BIT_GATE_ENABLE    = 2;
	localparam int COUNTER_CONTROL_LSB = 0;
	localparam logic [15:0] CONTROL_IMPL_MASK = 16'hBF7F;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int BIT_STAT_DIRECTION = 0;
	localparam int STAT_INPUTS_LSB    = 1;
	localparam int BIT_STAT_HOME_ARMED = 6;
	localparam int BIT_STAT_INIT_PEND = 7;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [15:0] CONTROL_RESET  = 16'h0000;
	localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
	localparam logic [1:0]  FILTER_LAST    = 2'h2;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;

	// ----------------------------------------
	// Modes and carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_QUADRATURE,
		MODE_EXT_UPDOWN,
		MODE_EXT_GATE,
		MODE_TIMER
	} counter_control_mode_t;

	typedef enum logic [2:0] {
		INIT_NONE,
		INIT_INDEX_CLEAR,
		INIT_NEXT_INDEX,
		INIT_FIRST_AFTER_HOME,
		INIT_SECOND_AFTER_HOME,
		INIT_GE_CLEAR,
		INIT_MODULO,
		INIT_MODULO_INDEX
	} position_init_mode_t;

	typedef struct packed {
		logic a;
		logic b;
	} phase_t;

	typedef struct packed {
		logic gate;
		logic home;
		logic index;
		logic b;
		logic a;
	} enc_in_t;

	typedef struct packed {
		logic up;
		logic down;
		logic bad;
	} step_t;

	typedef struct packed {
		logic [1:0] cnt;
		logic       out;
	} filt_t;

endpackage

// ### verilog/quadrature_position_decoder.sv
// Summary of operation
// - Keep a 32-bit position count, one step per phase state change.
// - Up on 10-11, 00-10, 11-01, 01-00 (A,B); reverse steps count down.
// - Both phases changing at once is invalid: no count, no direction change.
// - Unchanged phase state: no count, direction kept.
// - Direction status holds the last step direction decoded in quadrature mode while running.
// - Phase, index and home inputs pass noise filters first.
// - Enable bit 15 clear stops counters; registers stay accessible.
// - Stop-in-idle bit 13 set halts operation while system idles.
// - Init mode 000 ignores index; 001 clears count on every index that passes the index match check.
// - Mode 010 loads init value on the next index only.
// - Modes 011/100 load init value on first/second index after home.
// - Mode 101 clears count when it equals the greater-equal compare.
// - Mode 110 counts modulo; 111 counts modulo and clears on index.
// - Index match field bits 9-8: upper bit is B level, lower A level.
// - Quadrature mode: index clears count only at the matching phase levels.
// - Counter control 10 counts A rising edges, 11 counts timer ticks; both ignore init mode.
// - Control bits 14 and 7 always read zero.
// - Counter control: quadrature, ext up/down, ext gate, internal timer.
// - Divider codes 000-111 prescale by 1,2,4,8,16,32,64,256.
// - Polarity set defaults direction down; quadrature and external up/down override.
// - Gate enable lets the external gate decide whether counting happens.
`timescale 1ns/10ps
module quadrature_position_decoder
	import qdec_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        phase_a_in,
	input  wire logic        phase_b_in,
	input  wire logic        index_in,
	input  wire logic        home_in,
	input  wire logic        count_gate_in,
	input  wire logic        system_idle,
	output logic             count_direction
);

	typedef struct packed {
		logic [15:0] control;
		logic [31:0] position;
		logic [31:0] init_value;
		logic [31:0] ge_compare;
		logic [31:0] le_compare;
		logic        direction;
		enc_in_t     prev_in;
		logic        init_pending;
		logic        home_armed;
		logic        index_seen;
		logic [7:0]  prescale;
		logic [31:0] rdata;
		logic        waitreq;
	} core_t;

	core_t   st;
	core_t   next_st;
	enc_in_t raw_in;
	enc_in_t cur_in;
	step_t   step;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] lanes);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [7:0] prescale_last(input logic [2:0] code);
		logic [7:0] res;
		res = 8'h00;
		case (code)
			3'h0: res = 8'h00;
			3'h1: res = 8'h01;
			3'h2: res = 8'h03;
			3'h3: res = 8'h07;
			3'h4: res = 8'h0F;
			3'h5: res = 8'h1F;
			3'h6: res = 8'h3F;
			3'h7: res = 8'hFF;
			default: res = 8'h00;
		endcase
		return res;
	endfunction

	// ----------------------------------------
	// Input filters
	// ----------------------------------------
	assign raw_in = '{gate: count_gate_in, home: home_in, index: index_in,
		b: phase_b_in, a: phase_a_in};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_filt
			input_noise_filter u_filt (
				.mclk      (mclk),
				.sys_rst   (sys_rst),
				.raw_in    (raw_in[gi]),
				.clean_out (cur_in[gi])
			);
		end
	endgenerate

	phase_step_decoder u_dec (
		.prev_phase (phase_t'({st.prev_in.a, st.prev_in.b})),
		.cur_phase  (phase_t'({cur_in.a, cur_in.b})),
		.step       (step)
	);

	// ----------------------------------------
	// Decoded control fields
	// ----------------------------------------
	counter_control_mode_t cmode;
	position_init_mode_t   pim;
	logic                  run;
	logic                  idx_evt;
	logic                  home_evt;
	logic                  ext_edge;
	logic                  gate_ok;
	logic                  tick;
	logic                  req;
	logic [2:0]            word_sel;

	assign cmode    = counter_control_mode_t'(st.control[COUNTER_CONTROL_LSB +: 2]);
	assign pim      = position_init_mode_t'(st.control[POS_INIT_MODE_LSB +: 3]);
	assign run      = st.control[BIT_MODULE_ENABLE]
		&& !(st.control[BIT_STOP_IN_IDLE] && system_idle);
	assign home_evt = cur_in.home && !st.prev_in.home;
	assign idx_evt  = cur_in.index && !st.prev_in.index && ((cmode != MODE_QUADRATURE)
		|| ({cur_in.b, cur_in.a} == st.control[INDEX_MATCH_LSB +: 2]));
	assign ext_edge = cur_in.a && !st.prev_in.a;
	assign gate_ok  = !st.control[BIT_GATE_ENABLE] || cur_in.gate;
	// At or past the last count, so a smaller divider never stalls the tick
	assign tick     = st.prescale >= prescale_last(st.control[CLOCK_DIVIDER_LSB +: 3]);
	assign req      = avs_read || avs_write;
	assign word_sel = avs_address[4:2];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic        do_up;
		logic        do_down;
		logic        mod_on;
		logic [31:0] wr_val;
		do_up   = 1'b0;
		do_down = 1'b0;
		mod_on  = (pim == INIT_MODULO) || (pim == INIT_MODULO_INDEX);
		wr_val  = 32'h0000_0000;
		next_st = st;
		next_st.prev_in = cur_in;

		// Internal clock divider
		if (run) begin
			next_st.prescale = tick ? PRESCALE_RESET : st.prescale + 8'h01;
		end

		// Count source per counter control mode
		if (run && gate_ok) begin
			case (cmode)
				MODE_QUADRATURE: begin
					do_up   = step.up;
					do_down = step.down;
				end
				MODE_EXT_UPDOWN: begin
					do_up   = ext_edge && !cur_in.b;
					do_down = ext_edge && cur_in.b;
				end
				MODE_EXT_GATE: begin
					do_up   = ext_edge && !st.control[BIT_POLARITY];
					do_down = ext_edge && st.control[BIT_POLARITY];
				end
				MODE_TIMER: begin
					do_up   = tick && !st.control[BIT_POLARITY];
					do_down = tick && st.control[BIT_POLARITY];
				end
				default: begin
					do_up   = 1'b0;
					do_down = 1'b0;
				end
			endcase
		end

		// Direction status follows decoded quadrature steps only
		if (run && cmode == MODE_QUADRATURE && (step.up || step.down)) begin
			next_st.direction = step.up;
		end

		// Home tracking for the after-home modes
		if (run && home_evt) begin
			next_st.home_armed = 1'b1;
			next_st.index_seen = 1'b0;
		end

		// Position update, index initialization first
		if (!run) begin
			next_st.position = st.position;
		end else if (cmode == MODE_EXT_GATE || cmode == MODE_TIMER) begin
			if (do_up) begin
				next_st.position = st.position + 32'h0000_0001;
			end else if (do_down) begin
				next_st.position = st.position - 32'h0000_0001;
			end
		end else if (idx_evt && (pim == INIT_INDEX_CLEAR || pim == INIT_MODULO_INDEX)) begin
			next_st.position = WORD_RESET;
		end else if (idx_evt && pim == INIT_NEXT_INDEX && st.init_pending) begin
			next_st.position     = st.init_value;
			next_st.init_pending = 1'b0;
		end else if (idx_evt && st.home_armed && !home_evt && (pim == INIT_FIRST_AFTER_HOME
			|| (pim == INIT_SECOND_AFTER_HOME && st.index_seen))) begin
			next_st.position   = st.init_value;
			next_st.home_armed = 1'b0;
		end else if (pim == INIT_GE_CLEAR && st.position == st.ge_compare) begin
			next_st.position = WORD_RESET;
		end else if (do_up) begin
			next_st.position = (mod_on && st.position == st.ge_compare)
				? st.le_compare : st.position + 32'h0000_0001;
		end else if (do_down) begin
			next_st.position = (mod_on && st.position == st.le_compare)
				? st.ge_compare : st.position - 32'h0000_0001;
		end
		if (run && idx_evt && st.home_armed && !home_evt
			&& pim == INIT_SECOND_AFTER_HOME && !st.index_seen) begin
			next_st.index_seen = 1'b1;
		end

		// Register bus: one wait cycle, then answer
		if (!st.waitreq) begin
			next_st.waitreq = 1'b1;
			if (avs_write) begin
				case (word_sel)
					3'h0: begin
						wr_val = merge_bytes({16'h0000, st.control}, avs_writedata,
							avs_byteenable);
						next_st.control = wr_val[15:0] & CONTROL_IMPL_MASK;
						next_st.init_pending = 1'b1;
					end
					3'h1: next_st.position = merge_bytes(st.position, avs_writedata,
						avs_byteenable);
					3'h2: next_st.init_value = merge_bytes(st.init_value, avs_writedata,
						avs_byteenable);
					3'h3: next_st.ge_compare = merge_bytes(st.ge_compare, avs_writedata,
						avs_byteenable);
					3'h4: next_st.le_compare = merge_bytes(st.le_compare, avs_writedata,
						avs_byteenable);
					default: next_st.waitreq = 1'b1;
				endcase
			end
		end else if (req) begin
			next_st.waitreq = 1'b0;
			case (word_sel)
				3'h0: next_st.rdata = {16'h0000, st.control};
				3'h1: next_st.rdata = st.position;
				3'h2: next_st.rdata = st.init_value;
				3'h3: next_st.rdata = st.ge_compare;
				3'h4: next_st.rdata = st.le_compare;
				3'h5: next_st.rdata = {24'h00_0000, st.init_pending, st.home_armed,
					cur_in, st.direction};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st            <= '0;
			st.control    <= CONTROL_RESET;
			st.position   <= WORD_RESET;
			st.init_value <= WORD_RESET;
			st.ge_compare <= WORD_RESET;
			st.le_compare <= WORD_RESET;
			st.rdata      <= WORD_RESET;
			st.prescale   <= PRESCALE_RESET;
			st.waitreq    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata    = st.rdata;
	assign avs_waitrequest = st.waitreq;
	assign count_direction = st.direction;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic plain_quad;
	logic bus_write_now;
	assign plain_quad = run && gate_ok && cmode == MODE_QUADRATURE && pim == INIT_NONE;
	// Position writes override counting, so checks skip all bus write cycles
	assign bus_write_now = !st.waitreq && avs_write;

	sequence s_bus_take;
		req && st.waitreq;
	endsequence

	sequence s_bus_answer;
		!st.waitreq ##1 st.waitreq;
	endsequence

	property p_count_up;
		plain_quad && step.up && !bus_write_now |=> st.position == $past(st.position) + 32'h1;
	endproperty
	a_count_up: assert property (p_count_up) else $error("up step not counted");

	property p_count_down;
		plain_quad && step.down && !bus_write_now |=> st.position == $past(st.position) - 32'h1;
	endproperty
	a_count_down: assert property (p_count_down) else $error("down step not counted");

	property p_invalid_hold;
		plain_quad && step.bad && !bus_write_now
			|=> $stable(st.position) && $stable(st.direction);
	endproperty
	a_invalid_hold: assert property (p_invalid_hold) else $error("invalid step acted");

	property p_dir_only_on_step;
		!(step.up || step.down) |=> $stable(st.direction);
	endproperty
	a_dir_only_on_step: assert property (p_dir_only_on_step) else $error("direction moved");

	property p_disabled_hold;
		!run && !bus_write_now |=> $stable(st.position);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("count while stopped");

	property p_index_clear;
		run && cmode == MODE_QUADRATURE && pim == INIT_INDEX_CLEAR && idx_evt && !bus_write_now
			|=> st.position == 32'h0;
	endproperty
	a_index_clear: assert property (p_index_clear) else $error("index did not clear");

	property p_next_index_load;
		run && pim == INIT_NEXT_INDEX && cmode == MODE_QUADRATURE && st.init_pending && idx_evt
			&& !bus_write_now |=> st.position == $past(st.init_value) && !st.init_pending;
	endproperty
	a_next_index_load: assert property (p_next_index_load) else $error("init load missed");

	property p_ge_clear;
		run && cmode == MODE_QUADRATURE && pim == INIT_GE_CLEAR && st.position == st.ge_compare
			&& !idx_evt && !bus_write_now |=> st.position == 32'h0;
	endproperty
	a_ge_clear: assert property (p_ge_clear) else $error("compare clear missed");

	property p_ctrl_zero_bits;
		st.control[14] == 1'b0 && st.control[7] == 1'b0;
	endproperty
	a_ctrl_zero_bits: assert property (p_ctrl_zero_bits) else $error("reserved bit set");

	property p_bus_answer;
		s_bus_take |=> s_bus_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule
